// File: inc/pfs_pkg.sv
// Constants, timing figures and state codes of the power-fail sequencer
package pfs_pkg;
  // Clock rate and microsecond timebase
  localparam int PFS_CLK_MHZ = 100;
  localparam int PFS_TICK_TIME_US = 1;
  localparam int PFS_TICK_CYCLES = PFS_TICK_TIME_US * PFS_CLK_MHZ;
  localparam int PFS_US_PER_MS = 1000;
  // Power-off interrupt interval
  localparam int PFS_OFF_IRQ_TIME_MS = 5;
  localparam int PFS_OFF_IRQ_TICKS = PFS_OFF_IRQ_TIME_MS * PFS_US_PER_MS / PFS_TICK_TIME_US;
  // Delay from hold to delayed hold at power-up
  localparam int PFS_HOLD_DLY_TIME_US = 3;
  localparam int PFS_HOLD_DLY_TICKS = PFS_HOLD_DLY_TIME_US / PFS_TICK_TIME_US;
  // Widths
  localparam int PFS_TMR_W = 16;
  localparam int PFS_AGE_W = 4;
  localparam logic [PFS_TMR_W-1:0] PFS_TMR_ONE = 16'h0001;
  localparam logic [PFS_TMR_W-1:0] PFS_TMR_ZERO = 16'h0000;
  localparam logic [PFS_AGE_W-1:0] PFS_AGE_ZERO = 4'h0;
  localparam logic [PFS_AGE_W-1:0] PFS_AGE_ONE = 4'h1;

  typedef enum logic [2:0] {
    PFS_ST_DOWN = 3'h0,
    PFS_ST_UP = 3'h1,
    PFS_ST_RUN = 3'h2,
    PFS_ST_OFF_IRQ = 3'h3,
    PFS_ST_DECAY = 3'h4
  } pfs_state_t;
endpackage

// File: inc/pfs_tmr_if.sv
// Carrier between the sequencer and its interval timer
`timescale 1ns/1ns
interface pfs_tmr_if #(parameter int W = 16);
  logic tick;
  logic start;
  logic [W-1:0] load;
  logic expired;
  modport timer (output tick, output expired, input start, input load);
  modport user (input tick, input expired, output start, output load);
endinterface

// File: rtl/pfs_timer.sv
// Microsecond timebase and interval down-counter
`timescale 1ns/1ns
module pfs_timer
  import pfs_pkg::*;
#(
  parameter int TICK_DIV = PFS_TICK_CYCLES,
  parameter int W = PFS_TMR_W
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  pfs_tmr_if.timer t
);
  localparam int DIV_W = $clog2(TICK_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_DIV - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  localparam logic [W-1:0] CNT_ONE = W'(1);

  if (TICK_DIV < 1) begin : g_bad_div
    $error("pfs_timer: TICK_DIV must be at least 1");
  end

  logic [DIV_W-1:0] div_q;
  logic tick_q;
  logic [W-1:0] cnt_q;
  logic busy_q;
  logic expired_q;
  wire div_wrap = (div_q == DIV_LAST);
  wire last_tick = busy_q && tick_q && (cnt_q == CNT_ONE);

  // Free-running divider gives one tick per microsecond
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      div_q <= DIV_ZERO;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_wrap ? DIV_ZERO : div_q + DIV_W'(1);
      tick_q <= div_wrap;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      expired_q <= 1'b0;
    end else begin
      expired_q <= last_tick;
      if (t.start) begin
        cnt_q <= t.load;
        busy_q <= (t.load != '0);
      end else if (busy_q && tick_q) begin
        cnt_q <= cnt_q - CNT_ONE;
        busy_q <= !last_tick;
      end
    end
  end

  assign t.tick = tick_q;
  assign t.expired = expired_q;
endmodule // pfs_timer

// File: rtl/power_fail_sequencer.sv
// Power-fail and power-up sequencer for the core memory
`timescale 1ns/1ns
// Overview of operation
// - On power loss raise both the power-on-enable and power-off interrupts.
// - Hold the power-off interrupt for 5 ms after loss is detected.
// - After that interval raise hold until supplies decay to 15 percent.
// - Hold starts the memory reset-early sequence, inhibiting ports and timing.
// - While hold is up, ground the predrive drive voltage.
// - At power-up raise hold, then delayed hold 3 us later.
// - At power-up keep hold until supplies report stable, one to three seconds.
// - When hold drops after power-up, raise the power-on interrupt.
// - Disable predrive whenever +8V, +4V or +24V supplies reach their limits.
// - The supply check acts independently of the sequence state.
// - Shutdown request stays low normally and rises on airflow failure.
// - Hold forces the shutdown request low despite airflow failure.
// - Transitions yield three interrupts, reset-early trigger and predrive disable.
module power_fail_sequencer
  import pfs_pkg::*;
#(
  parameter int OFF_IRQ_TICKS = PFS_OFF_IRQ_TICKS,
  parameter int HOLD_DLY_TICKS = PFS_HOLD_DLY_TICKS,
  parameter int TICK_CYCLES = PFS_TICK_CYCLES
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic power_present,
  input wire logic supplies_stable,
  input wire logic supplies_decayed,
  input wire logic v8_low,
  input wire logic v4_low,
  input wire logic v24_low,
  input wire logic vneg8_low,
  input wire logic airflow_fail,
  output logic power_on_enable_irq,
  output logic power_off_irq,
  output logic power_on_irq,
  output logic start_stop_hold,
  output logic delayed_hold_predrive,
  output logic predrive_disable,
  output logic predrive_drive_voltage,
  output logic supply_shutdown_request
);
  localparam logic [PFS_TMR_W-1:0] OFF_LOAD = PFS_TMR_W'(OFF_IRQ_TICKS);
  localparam logic [PFS_AGE_W-1:0] AGE_MAX = PFS_AGE_W'(HOLD_DLY_TICKS);

  if (OFF_IRQ_TICKS < 1 || OFF_IRQ_TICKS >= (1 << PFS_TMR_W)) begin : g_bad_off
    $error("power_fail_sequencer: OFF_IRQ_TICKS out of range");
  end
  if (HOLD_DLY_TICKS < 1 || HOLD_DLY_TICKS >= (1 << PFS_AGE_W)) begin : g_bad_dly
    $error("power_fail_sequencer: HOLD_DLY_TICKS out of range");
  end
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("power_fail_sequencer: TICK_CYCLES must be at least 1");
  end

  // Microsecond timebase and power-off interval counter
  pfs_tmr_if #(.W(PFS_TMR_W)) tmr ();

  pfs_timer #(
    .TICK_DIV(TICK_CYCLES),
    .W(PFS_TMR_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .t(tmr.timer)
  );

  // Sequence state and timer control
  pfs_state_t state_q;
  pfs_state_t state_d;
  logic start_q;
  logic [PFS_AGE_W-1:0] age_q;
  // Output registers
  logic on_enable_q;
  logic off_irq_q;
  logic on_irq_q;
  logic hold_q;
  logic dly_hold_q;
  logic pd_dis_q;
  logic vc_q;
  logic shut_q;

  // States in which the memory is kept in reset-early; DOWN is included so that
  // a cold start never sees the drive switches live before supplies settle
  function automatic logic pfs_holds(input pfs_state_t s);
    pfs_holds = (s != PFS_ST_RUN) && (s != PFS_ST_OFF_IRQ);
  endfunction

  // True on the one edge at which the sequence passes between two given states
  function automatic logic pfs_moves(
    input pfs_state_t cur,
    input pfs_state_t nxt,
    input pfs_state_t from,
    input pfs_state_t to
  );
    pfs_moves = (cur == from) && (nxt == to);
  endfunction

  // Sequence transitions
  always_comb begin
    state_d = state_q;
    case (state_q)
      PFS_ST_DOWN: begin
        if (power_present) begin
          state_d = PFS_ST_UP;
        end
      end
      PFS_ST_UP: begin
        // Stable supplies are held off until hold has aged the full delay
        if (supplies_stable && age_q == AGE_MAX) begin
          state_d = PFS_ST_RUN;
        end
      end
      PFS_ST_RUN: begin
        if (!power_present) begin
          state_d = PFS_ST_OFF_IRQ;
        end
      end
      PFS_ST_OFF_IRQ: begin
        // Power returning here is ignored; the sequence runs on to DOWN
        if (tmr.expired) begin
          state_d = PFS_ST_DECAY;
        end
      end
      PFS_ST_DECAY: begin
        if (supplies_decayed) begin
          state_d = PFS_ST_DOWN;
        end
      end
      default: begin
        state_d = PFS_ST_DOWN;
      end
    endcase
  end

  wire enter_off = pfs_moves(state_q, state_d, PFS_ST_RUN, PFS_ST_OFF_IRQ);
  wire leave_up = pfs_moves(state_q, state_d, PFS_ST_UP, PFS_ST_RUN);
  // Hold is up in every state except running and the power-off interval
  wire hold_d = pfs_holds(state_d);
  wire off_irq_d = (state_d == PFS_ST_OFF_IRQ);
  wire on_irq_d = leave_up;
  // Age of the current hold in microsecond ticks, saturating at the delay
  wire age_full = (age_q == AGE_MAX);
  wire age_step = tmr.tick && !age_full;
  wire [PFS_AGE_W-1:0] age_inc = age_q + PFS_AGE_ONE;
  wire [PFS_AGE_W-1:0] age_d = !hold_q ? PFS_AGE_ZERO : (age_step ? age_inc : age_q);
  // Delayed hold needs hold on both sides of the edge, so it drops with hold
  wire dly_hold_d = hold_d && hold_q && (age_d == AGE_MAX);
  // Supply check does not look at the sequence
  localparam int SUPPLY_N = 4;
  wire [SUPPLY_N-1:0] supply_low_vec = {vneg8_low, v24_low, v4_low, v8_low};
  wire supply_low = |supply_low_vec;
  wire pd_dis_d = supply_low || dly_hold_d;
  wire vc_d = !(hold_d || pd_dis_d);
  // Next-state hold, so the request drops on the very edge at which hold rises
  wire shut_d = airflow_fail && !hold_d;
  wire on_enable_d = enter_off ? 1'b1 : (leave_up ? 1'b0 : on_enable_q);

  // The timer start is registered, so the timer loads one clock cycle after the power-off state is entered
  assign tmr.start = start_q;
  assign tmr.load = OFF_LOAD;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      state_q <= PFS_ST_DOWN;
    end else begin
      state_q <= state_d;
    end
  end

  // Hold age and timer kick
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      start_q <= 1'b0;
      age_q <= PFS_AGE_ZERO;
    end else begin
      start_q <= enter_off;
      age_q <= age_d;
    end
  end

  // Interrupt requests to the processor
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      on_enable_q <= 1'b0;
      off_irq_q <= 1'b0;
      on_irq_q <= 1'b0;
    end else begin
      on_enable_q <= on_enable_d;
      off_irq_q <= off_irq_d;
      on_irq_q <= on_irq_d;
    end
  end

  // Hold and drive protection come out of reset in their safe state
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      hold_q <= 1'b1;
      dly_hold_q <= 1'b0;
      pd_dis_q <= 1'b1;
      vc_q <= 1'b0;
      shut_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      dly_hold_q <= dly_hold_d;
      pd_dis_q <= pd_dis_d;
      vc_q <= vc_d;
      shut_q <= shut_d;
    end
  end

  assign power_on_enable_irq = on_enable_q;
  assign power_off_irq = off_irq_q;
  assign power_on_irq = on_irq_q;
  assign start_stop_hold = hold_q;
  assign delayed_hold_predrive = dly_hold_q;
  assign predrive_disable = pd_dis_q;
  assign predrive_drive_voltage = vc_q;
  assign supply_shutdown_request = shut_q;
endmodule // power_fail_sequencer

// File: test/pfs_monitor.sv
// Checker of the sequencer's port behaviour
`timescale 1ns/1ns
module pfs_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic power_present,
  input wire logic supplies_stable,
  input wire logic supplies_decayed,
  input wire logic v8_low,
  input wire logic v4_low,
  input wire logic v24_low,
  input wire logic vneg8_low,
  input wire logic airflow_fail,
  input wire logic power_on_enable_irq,
  input wire logic power_off_irq,
  input wire logic power_on_irq,
  input wire logic start_stop_hold,
  input wire logic delayed_hold_predrive,
  input wire logic predrive_disable,
  input wire logic predrive_drive_voltage,
  input wire logic supply_shutdown_request
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  wire any_low = v8_low | v4_low | v24_low | vneg8_low;
  a_loss_irqs: assert property (!power_present && !start_stop_hold && !power_off_irq
    |=> power_off_irq && power_on_enable_irq) else $error("loss irqs");
  a_off_len: assert property ($rose(power_off_irq)
    |-> power_off_irq [*8] ##[1:6] !power_off_irq) else $error("off len");
  a_hold_after_off: assert property ($fell(power_off_irq) |-> start_stop_hold) else $error("hold");
  a_hold_grounds: assert property (start_stop_hold |-> !predrive_drive_voltage) else $error("drv");
  a_delay_hold: assert property ($rose(delayed_hold_predrive)
    |-> $past(start_stop_hold, 4) && predrive_disable) else $error("delayed");
  a_on_pulse: assert property ($fell(start_stop_hold)
    |-> power_on_irq && !power_on_enable_irq ##1 !power_on_irq) else $error("on irq");
  a_low_disable: assert property (any_low
    |=> predrive_disable && !predrive_drive_voltage) else $error("low");
  a_shut_on: assert property (airflow_fail && power_present && !start_stop_hold
    |=> supply_shutdown_request) else $error("shut on");
  a_shut_forced: assert property (supply_shutdown_request
    |-> !start_stop_hold && $past(airflow_fail)) else $error("shut off");
  c_on: cover property ($fell(start_stop_hold));
  c_off: cover property ($fell(power_off_irq));
  c_shut: cover property (supply_shutdown_request);
endmodule // pfs_monitor
bind power_fail_sequencer pfs_monitor u_mon (.*);

// File: test/pfs_partner.sv
// Model of the interrupt handler and memory reset-early logic
`timescale 1ns/1ns
module pfs_partner (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic power_off_irq,
  input wire logic power_on_irq,
  input wire logic start_stop_hold,
  output logic ports_inhibited,
  output logic [3:0] saves_q,
  output logic [3:0] restores_q
);
  logic off_q;
  assign ports_inhibited = start_stop_hold;
  always_ff @(posedge ref_clk) begin
    off_q <= power_off_irq;
    if (!reset_n) begin
      saves_q <= 4'h0;
      restores_q <= 4'h0;
    end else begin
      saves_q <= saves_q + {3'h0, power_off_irq & ~off_q};
      restores_q <= restores_q + {3'h0, power_on_irq};
    end
  end
endmodule // pfs_partner

// File: test/tb_power_fail_sequencer.sv
// Self-checking bench of the power-fail sequencer
`timescale 1ns/1ns
module tb_power_fail_sequencer;
  logic ref_clk = 0, reset_n = 0, power_present = 0, supplies_stable = 0;
  logic supplies_decayed = 0, airflow_fail = 0;
  logic v8_low = 0, v4_low = 0, v24_low = 0, vneg8_low = 0;
  logic power_on_enable_irq, power_off_irq, power_on_irq, start_stop_hold;
  logic delayed_hold_predrive, predrive_disable, predrive_drive_voltage;
  logic supply_shutdown_request, ports_inhibited;
  logic [3:0] saves_q, restores_q;
  int fails = 0, comparisons = 0, cycles = 0;
  power_fail_sequencer #(.OFF_IRQ_TICKS(4), .HOLD_DLY_TICKS(3), .TICK_CYCLES(2)) dut (.*);
  pfs_partner partner (.*);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %b got %b", what, exp, got);
    end
  endtask
  task automatic chk4(input string what, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic after_reset;
    step(10);
    chk("hold", 1'b1, start_stop_hold);
    chk("drive", 1'b0, predrive_drive_voltage);
    chk("disable", 1'b1, predrive_disable);
    chk("off_irq", 1'b0, power_off_irq);
    reset_n = 1;
  endtask
  task automatic power_up;
    int n;
    power_present = 1;
    step(10);
    chk("hold", 1'b1, start_stop_hold);
    chk("delayed", 1'b1, delayed_hold_predrive);
    chk("inhibit", 1'b1, ports_inhibited);
    supplies_stable = 1;
    n = 0;
    while (start_stop_hold !== 1'b0 && n < 20) begin
      step(1);
      n++;
    end
    chk("on_irq", 1'b1, power_on_irq);
    chk("drop", 1'b1, n < 3);
    supplies_stable = 0;
    step(1);
    chk("on_irq", 1'b0, power_on_irq);
    chk("on_enable", 1'b0, power_on_enable_irq);
    chk("drive", 1'b1, predrive_drive_voltage);
  endtask
  task automatic supply_low;
    for (int i = 0; i < 4; i++) begin
      {vneg8_low, v24_low, v4_low, v8_low} = 4'h1 << i;
      step(2);
      chk("disable", 1'b1, predrive_disable);
      chk("drive", 1'b0, predrive_drive_voltage);
      {vneg8_low, v24_low, v4_low, v8_low} = 4'h0;
      step(2);
      chk("disable", 1'b0, predrive_disable);
    end
  endtask
  task automatic airflow;
    airflow_fail = 1;
    step(2);
    chk("shutdown", 1'b1, supply_shutdown_request);
    airflow_fail = 0;
    step(2);
    chk("shutdown", 1'b0, supply_shutdown_request);
  endtask
  task automatic power_loss;
    int n;
    power_present = 0;
    step(1);
    chk("off_irq", 1'b1, power_off_irq);
    chk("on_enable", 1'b1, power_on_enable_irq);
    n = 1;
    while (power_off_irq !== 1'b0 && n < 30) begin
      step(1);
      n++;
    end
    chk("off_len", 1'b1, n >= 9 && n <= 13);
    chk("hold", 1'b1, start_stop_hold);
    chk("drive", 1'b0, predrive_drive_voltage);
    airflow_fail = 1;
    power_present = 1;
    step(8);
    chk("shutdown", 1'b0, supply_shutdown_request);
    chk("hold", 1'b1, start_stop_hold);
    chk("disable", 1'b1, predrive_disable);
    airflow_fail = 0;
    supplies_decayed = 1;
    step(2);
    supplies_decayed = 0;
    power_up();
  endtask
  task automatic finish_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      finish_test();
    end
  end
  initial begin
    after_reset();
    power_up();
    supply_low();
    airflow();
    power_loss();
    chk4("saves", 4'h1, saves_q);
    chk4("restores", 4'h2, restores_q);
    finish_test();
  end
endmodule // tb_power_fail_sequencer
